/* src/rsc_reset_source_control.sv */
// Purpose: Reset source control: level select decode, reset requests, cause flags.
// Assumes: Core sleep/idle state, watchdog expiry and comparator come from outside.
// Notes: Registers are reached over AXI4-Lite; aresetn acts as the power-on reset.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "rsc_defs.svh"

// Function
// - Five level codes select 1.7, 1.9, 2.55, 3.15, 3.8 V trip levels.
// - Code F0 disables brown-out reset entirely.
// - Any other level code resets after soft delay and restores power-on value.
// - Brown-out reset only after filter time; level select kept unchanged.
// - Brown-out event flag, cause bit 2, set on brown-out; cleared by writing zero.
// - Illegal level code flag, cause bit 1; cleared only by writing zero or by power-on.
// - Upper four cause register bits read as zero.
// - Writing 55H to self-program control resets the whole device.
// - Watchdog expiry during running sets the expiry flag.
// - Watchdog expiry in sleep clears only PC and SP, sets both flags.
// - Power-on clears both flags; pin or brown-out reset leaves them.
// - Watchdog expiry while running keeps power-down flag, sets expiry flag.
// - Power-on zeroes PC, disables interrupts, stops timers, stack pointer to top.
// - After any reset except watchdog expiry in sleep, watchdog and time bases cleared; watchdog then starts counting.
// - After power-on all general-purpose ports become inputs.
// - Brown-out detection is off in idle or sleep mode.
// - Undefined pin select code resets after soft delay, sets pin select flag.
module rsc_reset_source_control
  import rsc_pkg::*;
#(
  parameter int unsigned BOR_FILTER_CYC =
    (`RSC_BOR_FILTER_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS,
  parameter int unsigned SOFT_DELAY_CYC =
    (`RSC_SOFT_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`RSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_supply,
  input wire logic reset_pin_n,
  input wire logic low_power_mode,
  input wire logic wdt_expiry,
  input wire logic wdt_ctrl_illegal,
  output logic device_reset,
  output logic pc_sp_clear,
  output logic irq_disable_all,
  output logic timers_off,
  output logic stack_to_top,
  output logic wdt_tb_clear,
  output logic ports_as_input,
  output logic brownout_enable,
  output logic wdt_expiry_flag,
  output logic powerdown_flag,
  output logic irq
);

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function automatic rsc_trip_t rsc_trip_decode(input logic [7:0] code);
    case (code)
      `RSC_LVL_1V7: return RSC_TRIP_1V7;
      `RSC_LVL_1V9: return RSC_TRIP_1V9;
      `RSC_LVL_2V55: return RSC_TRIP_2V55;
      `RSC_LVL_3V15: return RSC_TRIP_3V15;
      `RSC_LVL_3V8: return RSC_TRIP_3V8;
      `RSC_LVL_OFF: return RSC_TRIP_OFF;
      default: return RSC_TRIP_BAD;
    endcase
  endfunction : rsc_trip_decode

  function automatic logic rsc_addr_mapped(input logic [`RSC_ADDR_W-1:0] addr);
    case (addr)
      `RSC_A_LEVEL, `RSC_A_CAUSE, `RSC_A_PINSEL, `RSC_A_SELFPROG,
      `RSC_A_STATUS, `RSC_A_IRQ_STAT, `RSC_A_IRQ_CLR, `RSC_A_IRQ_EN: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : rsc_addr_mapped

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] level_sel_r;
  logic [7:0] level_sel_nxt;
  logic [7:0] pin_sel_r;
  logic [7:0] pin_sel_nxt;
  logic [`RSC_CAUSE_W-1:0] cause_r;
  logic [`RSC_CAUSE_W-1:0] cause_nxt;
  logic [`RSC_CAUSE_W-1:0] cause_set_w;
  logic [`RSC_CAUSE_W-1:0] cause_keep_w;
  logic [`RSC_EV_W-1:0] irq_stat_r;
  logic [`RSC_EV_W-1:0] irq_stat_nxt;
  logic [`RSC_EV_W-1:0] irq_en_r;
  logic [`RSC_EV_W-1:0] irq_ev_w;
  logic [`RSC_EV_W-1:0] irq_clr_w;
  logic to_r;
  logic to_nxt;
  logic pdf_r;
  logic pdf_nxt;
  rsc_state_t state_r;
  rsc_state_t state_nxt;
  rsc_kind_t kind_r;
  rsc_kind_t kind_nxt;
  logic [3:0] hold_cnt_r;
  logic [3:0] hold_cnt_nxt;
  logic full_rst_r;
  logic warm_rst_r;
  rsc_trip_t trip_w;
  logic level_bad_w;
  logic pin_bad_w;
  logic low_supply_s;
  logic reset_pin_s;
  logic bor_expired_w;
  logic soft_expired_w;
  logic running_w;
  logic req_pin_w;
  logic req_selfprog_w;
  logic req_any_w;
  logic enter_w;
  logic aw_held_r;
  logic w_held_r;
  logic [`RSC_ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_data_w;
  logic wr_fire_w;
  logic wr_lane0_w;
  logic wr_level_w;
  logic wr_cause_w;
  logic wr_pin_w;
  logic wr_irq_clr_w;
  logic wr_irq_en_w;
  logic ar_fire_w;

  // ****************************************************************
  // Input conditioning and timers
  // ****************************************************************
  rsc_sync3 #(.RST_VAL(1'b0)) u_sync_low
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(low_supply),
    .dout(low_supply_s)
  );

  rsc_sync3 #(.RST_VAL(1'b1)) u_sync_pin
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(reset_pin_n),
    .dout(reset_pin_s)
  );

  assign trip_w = rsc_trip_decode(level_sel_r);
  assign level_bad_w = (trip_w == RSC_TRIP_BAD);
  assign pin_bad_w = (pin_sel_r != `RSC_PIN_IO) && (pin_sel_r != `RSC_PIN_RES);
  assign brownout_enable = (trip_w != RSC_TRIP_OFF) && !level_bad_w
    && !low_power_mode;
  assign running_w = (state_r == RSC_ST_RUN);

  rsc_hold_timer #(.LEN(BOR_FILTER_CYC)) u_bor_filter
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(running_w && brownout_enable && low_supply_s),
    .expired(bor_expired_w)
  );

  rsc_hold_timer #(.LEN(SOFT_DELAY_CYC)) u_soft_delay
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(running_w && (level_bad_w || pin_bad_w)),
    .expired(soft_expired_w)
  );

  // ****************************************************************
  // Reset request arbitration
  // ****************************************************************
  assign req_pin_w = (pin_sel_r == `RSC_PIN_RES) && !reset_pin_s;
  assign req_selfprog_w = wr_fire_w && wr_lane0_w && (waddr_r == `RSC_A_SELFPROG)
    && (wdata_r[7:0] == `RSC_SELFPROG_RST);
  assign req_any_w = req_pin_w || bor_expired_w || soft_expired_w || wdt_ctrl_illegal
    || req_selfprog_w || wdt_expiry;
  assign enter_w = running_w && req_any_w;

  assign kind_nxt = !enter_w ? kind_r :
    req_pin_w ? RSC_RK_PIN :
    bor_expired_w ? RSC_RK_BOR :
    (soft_expired_w || wdt_ctrl_illegal) ? RSC_RK_SOFT :
    req_selfprog_w ? RSC_RK_SELFPROG :
    low_power_mode ? RSC_RK_WDT_SLEEP : RSC_RK_WDT_RUN;

  always_comb
  begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      RSC_ST_RUN:
      begin
        hold_cnt_nxt = 4'h0;
        if (enter_w)
        begin
          state_nxt = RSC_ST_HOLD;
        end
      end
      RSC_ST_HOLD:
      begin
        hold_cnt_nxt = hold_cnt_r + 4'h1;
        if (hold_cnt_r == `RSC_HOLD_LAST)
        begin
          state_nxt = RSC_ST_RUN;
        end
      end
      default:
      begin
        state_nxt = RSC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= RSC_ST_HOLD;
      kind_r <= RSC_RK_POR;
      hold_cnt_r <= 4'h0;
      full_rst_r <= 1'b1;
      warm_rst_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      full_rst_r <= (state_nxt == RSC_ST_HOLD) && (kind_nxt != RSC_RK_WDT_SLEEP);
      warm_rst_r <= (state_nxt == RSC_ST_HOLD) && (kind_nxt == RSC_RK_WDT_SLEEP);
    end
  end

  assign device_reset = full_rst_r;
  assign pc_sp_clear = full_rst_r || warm_rst_r;
  assign irq_disable_all = full_rst_r;
  assign timers_off = full_rst_r;
  assign stack_to_top = full_rst_r;
  assign wdt_tb_clear = full_rst_r;
  assign ports_as_input = full_rst_r;

  // ****************************************************************
  // Flags and control registers
  // ****************************************************************
  assign cause_set_w = {soft_expired_w && pin_bad_w,
                        bor_expired_w,
                        soft_expired_w && level_bad_w,
                        wdt_ctrl_illegal};
  assign cause_keep_w = wr_cause_w ? wdata_r[`RSC_CAUSE_W-1:0] : {`RSC_CAUSE_W{1'b1}};
  assign cause_nxt = (cause_r & cause_keep_w) | cause_set_w;

  assign level_sel_nxt = (enter_w && (kind_nxt != RSC_RK_BOR)
    && (kind_nxt != RSC_RK_WDT_SLEEP)) ? `RSC_LVL_POR :
    wr_level_w ? wdata_r[7:0] : level_sel_r;
  assign pin_sel_nxt = (enter_w && (kind_nxt != RSC_RK_WDT_SLEEP)) ? `RSC_PIN_POR :
    wr_pin_w ? wdata_r[7:0] : pin_sel_r;

  assign to_nxt = (enter_w && ((kind_nxt == RSC_RK_WDT_RUN)
    || (kind_nxt == RSC_RK_WDT_SLEEP))) ? 1'b1 : to_r;
  assign pdf_nxt = (enter_w && (kind_nxt == RSC_RK_WDT_SLEEP)) ? 1'b1 : pdf_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_sel_r <= `RSC_LVL_POR;
      pin_sel_r <= `RSC_PIN_POR;
      cause_r <= {`RSC_CAUSE_W{1'b0}};
      to_r <= 1'b0;
      pdf_r <= 1'b0;
    end
    else
    begin
      level_sel_r <= level_sel_nxt;
      pin_sel_r <= pin_sel_nxt;
      cause_r <= cause_nxt;
      to_r <= to_nxt;
      pdf_r <= pdf_nxt;
    end
  end

  assign wdt_expiry_flag = to_r;
  assign powerdown_flag = pdf_r;

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_ev_w = {enter_w && (kind_nxt == RSC_RK_WDT_RUN || kind_nxt == RSC_RK_WDT_SLEEP),
                     req_selfprog_w, cause_set_w};
  assign irq_clr_w = wr_irq_clr_w ? wdata_r[`RSC_EV_W-1:0] : {`RSC_EV_W{1'b0}};
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr_w) | irq_ev_w;
  assign irq = |(irq_stat_r & irq_en_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_r <= {`RSC_EV_W{1'b0}};
      irq_en_r <= {`RSC_EV_W{1'b0}};
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= wr_irq_en_w ? wdata_r[`RSC_EV_W-1:0] : irq_en_r;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_fire_w = aw_held_r && w_held_r && !bvalid_r;
  assign wr_lane0_w = wstrb_r[0];
  assign wr_level_w = wr_fire_w && wr_lane0_w && (waddr_r == `RSC_A_LEVEL);
  assign wr_cause_w = wr_fire_w && wr_lane0_w && (waddr_r == `RSC_A_CAUSE);
  assign wr_pin_w = wr_fire_w && wr_lane0_w && (waddr_r == `RSC_A_PINSEL);
  assign wr_irq_clr_w = wr_fire_w && wr_lane0_w && (waddr_r == `RSC_A_IRQ_CLR);
  assign wr_irq_en_w = wr_fire_w && wr_lane0_w && (waddr_r == `RSC_A_IRQ_EN);
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= {`RSC_ADDR_W{1'b0}};
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RSC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end
      else if (wr_fire_w)
      begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (wr_fire_w)
      begin
        w_held_r <= 1'b0;
      end
      if (wr_fire_w)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= rsc_addr_mapped(waddr_r) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign ar_fire_w = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  assign rd_data_w =
    (s_axi_araddr == `RSC_A_LEVEL) ? {24'h000000, level_sel_r} :
    (s_axi_araddr == `RSC_A_CAUSE) ? {28'h0000000, cause_r} :
    (s_axi_araddr == `RSC_A_PINSEL) ? {24'h000000, pin_sel_r} :
    (s_axi_araddr == `RSC_A_STATUS) ? {25'h0, trip_w, low_power_mode,
                                       brownout_enable, pdf_r, to_r} :
    (s_axi_araddr == `RSC_A_IRQ_STAT) ? {26'h0, irq_stat_r} :
    (s_axi_araddr == `RSC_A_IRQ_EN) ? {26'h0, irq_en_r} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= `RSC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (ar_fire_w)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rsc_addr_mapped(s_axi_araddr) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      rdata_r <= rd_data_w;
    end
    else if (s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : rsc_reset_source_control

/* include/rsc_defs.svh */
// Purpose: Named constants of the reset source control block.
// Assumes: Included by every design file of the block and by the bench; the package does not include it.
// Notes: Offsets are byte addresses on the register bus.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define RSC_CLK_PERIOD_NS 10
`define RSC_BOR_FILTER_NS 1000
`define RSC_SOFT_DELAY_NS 500
`define RSC_HOLD_LAST 4'h7
`define RSC_TIMER_W 16

// ****************************************************************
// Codes
// ****************************************************************
`define RSC_LVL_1V7 8'h66
`define RSC_LVL_1V9 8'h55
`define RSC_LVL_2V55 8'h33
`define RSC_LVL_3V15 8'h99
`define RSC_LVL_3V8 8'hAA
`define RSC_LVL_OFF 8'hF0
`define RSC_LVL_POR 8'h66
`define RSC_PIN_IO 8'h55
`define RSC_PIN_RES 8'hAA
`define RSC_PIN_POR 8'h55
`define RSC_SELFPROG_RST 8'h55

// ****************************************************************
// Register map and fields
// ****************************************************************
`define RSC_ADDR_W 8
`define RSC_A_LEVEL 8'h00
`define RSC_A_CAUSE 8'h04
`define RSC_A_PINSEL 8'h08
`define RSC_A_SELFPROG 8'h0C
`define RSC_A_STATUS 8'h10
`define RSC_A_IRQ_STAT 8'h14
`define RSC_A_IRQ_CLR 8'h18
`define RSC_A_IRQ_EN 8'h1C
`define RSC_CAUSE_W 4
`define RSC_CAUSE_WDT 0
`define RSC_CAUSE_ILL 1
`define RSC_CAUSE_BOR 2
`define RSC_CAUSE_PIN 3
`define RSC_EV_W 6
`define RSC_EV_SELFPROG 4
`define RSC_EV_WDT 5
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

`endif

/* include/rsc_pkg.sv */
// Purpose: Types shared by the reset source control block.
// Assumes: rsc_defs.svh holds the numeric constants.
// Notes: Enumerations carry explicit binary codes.
package rsc_pkg;

  typedef enum logic [2:0]
  {
    RSC_TRIP_1V7 = 3'b000,
    RSC_TRIP_1V9 = 3'b001,
    RSC_TRIP_2V55 = 3'b010,
    RSC_TRIP_3V15 = 3'b011,
    RSC_TRIP_3V8 = 3'b100,
    RSC_TRIP_OFF = 3'b101,
    RSC_TRIP_BAD = 3'b110
  } rsc_trip_t;

  typedef enum logic [0:0]
  {
    RSC_ST_RUN = 1'b0,
    RSC_ST_HOLD = 1'b1
  } rsc_state_t;

  typedef enum logic [2:0]
  {
    RSC_RK_POR = 3'b000,
    RSC_RK_PIN = 3'b001,
    RSC_RK_BOR = 3'b010,
    RSC_RK_SOFT = 3'b011,
    RSC_RK_SELFPROG = 3'b100,
    RSC_RK_WDT_RUN = 3'b101,
    RSC_RK_WDT_SLEEP = 3'b110
  } rsc_kind_t;

endpackage : rsc_pkg

/* src/rsc_sync3.sv */
// Purpose: Three-stage synchroniser for an asynchronous level.
// Assumes: Input may change at any time relative to aclk.
// Notes: The output follows only once stages two and three agree.
`include "rsc_defs.svh"
module rsc_sync3
  import rsc_pkg::*;
#(
  parameter bit RST_VAL = 1'b0
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic agree_w;

  assign agree_w = (s2_r == s3_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree_w)
      begin
        dout <= s3_r;
      end
    end
  end

endmodule : rsc_sync3

/* src/rsc_hold_timer.sv */
// Purpose: Counts cycles while a condition holds and flags when it lasted LEN cycles.
// Assumes: LEN fits the timer width and is at least one.
// Notes: Dropping run restarts the count from zero.
`include "rsc_defs.svh"
module rsc_hold_timer
  import rsc_pkg::*;
#(
  parameter int unsigned LEN = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic expired
);

  localparam logic [`RSC_TIMER_W-1:0] LEN_W = `RSC_TIMER_W'(LEN);

  logic [`RSC_TIMER_W-1:0] cnt_r;

  assign expired = run && (cnt_r == LEN_W);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r != LEN_W)
    begin
      cnt_r <= cnt_r + `RSC_TIMER_W'(1);
    end
  end

endmodule : rsc_hold_timer

/* verification/rsc_asserts.sv */
// Purpose: Port-level checks of the reset source control block.
// Assumes: Bound to the top module; one clock, synchronous reset.
// Notes: Watchdog checks assume no other reset request in the same cycle.
module rsc_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_power_mode,
  input wire logic wdt_expiry,
  input wire logic device_reset,
  input wire logic pc_sp_clear,
  input wire logic irq_disable_all,
  input wire logic timers_off,
  input wire logic stack_to_top,
  input wire logic wdt_tb_clear,
  input wire logic ports_as_input,
  input wire logic brownout_enable,
  input wire logic wdt_expiry_flag,
  input wire logic powerdown_flag,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic idle_w = !device_reset && !pc_sp_clear;

  chk_reset_copies: assert property (
    {irq_disable_all, timers_off, stack_to_top, wdt_tb_clear, ports_as_input}
      == {5{device_reset}} && (!device_reset || pc_sp_clear))
    else $error("reset copies differ");
  chk_hold_len: assert property (
    $rose(device_reset) |-> device_reset [*8] ##[1:2] !device_reset)
    else $error("reset hold length wrong");
  chk_por_flags: assert property (
    $rose(aresetn) |-> !wdt_expiry_flag && !powerdown_flag && device_reset)
    else $error("power-on flags wrong");
  chk_wdt_run: assert property (
    wdt_expiry && !low_power_mode && idle_w
      |=> device_reset && wdt_expiry_flag && $stable(powerdown_flag))
    else $error("running watchdog reset wrong");
  chk_wdt_sleep: assert property (
    wdt_expiry && low_power_mode && idle_w
      |=> pc_sp_clear && !device_reset && wdt_expiry_flag && powerdown_flag)
    else $error("sleep watchdog reset wrong");
  chk_flags_keep: assert property (
    !$fell(wdt_expiry_flag) && !$fell(powerdown_flag))
    else $error("status flag dropped");
  chk_expiry_cause: assert property (
    $rose(wdt_expiry_flag) |-> $past(wdt_expiry))
    else $error("expiry flag without expiry");
  chk_pd_cause: assert property (
    $rose(powerdown_flag) |-> $past(wdt_expiry) && $past(low_power_mode))
    else $error("powerdown flag without sleep expiry");
  chk_bor_sleep: assert property (
    brownout_enable |-> !low_power_mode)
    else $error("brownout enabled in sleep");

  cov_full_reset: cover property ($rose(device_reset));
  cov_warm_reset: cover property ($rose(pc_sp_clear) && !device_reset);
  cov_irq: cover property (irq);
endmodule : rsc_chk

bind rsc_reset_source_control rsc_chk i_rsc_chk
(
  .aclk, .aresetn, .low_power_mode, .wdt_expiry, .device_reset, .pc_sp_clear,
  .irq_disable_all, .timers_off, .stack_to_top, .wdt_tb_clear, .ports_as_input,
  .brownout_enable, .wdt_expiry_flag, .powerdown_flag, .irq
);

/* verification/tb_top.sv */
// Purpose: Self-checking bench of the reset source control block.
// Assumes: Short filter and soft delay parameters.
// Notes: Drives the register bus and event inputs directly.
`include "rsc_defs.svh"
module tb_top
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, low_supply, reset_pin_n, low_power_mode, wdt_expiry, wdt_ctrl_illegal;
  logic [`RSC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic device_reset, pc_sp_clear, irq_disable_all, timers_off, stack_to_top;
  logic wdt_tb_clear, ports_as_input, brownout_enable, wdt_expiry_flag, powerdown_flag, irq;
  logic [7:0] codes [6] = '{`RSC_LVL_1V7, `RSC_LVL_1V9, `RSC_LVL_2V55,
    `RSC_LVL_3V15, `RSC_LVL_3V8, `RSC_LVL_OFF};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  rsc_reset_source_control #(.BOR_FILTER_CYC(4), .SOFT_DELAY_CYC(3)) i_rsc_reset_source_control
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_supply, .reset_pin_n,
    .low_power_mode, .wdt_expiry, .wdt_ctrl_illegal, .device_reset, .pc_sp_clear,
    .irq_disable_all, .timers_off, .stack_to_top, .wdt_tb_clear, .ports_as_input,
    .brownout_enable, .wdt_expiry_flag, .powerdown_flag, .irq
  );

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (!s_axi_bvalid)
      @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rdc

  // Waits up to n cycles for a reset output, checks both, then lets the hold end.
  task automatic see(input int n, input logic [1:0] e);
    int i;
    i = 0;
    while (i < n && !(device_reset || pc_sp_clear))
    begin
      @(posedge aclk);
      i++;
    end
    chk({device_reset, pc_sp_clear}, e);
    low_supply <= 1'b0;
    reset_pin_n <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask : see

  task automatic wdt(input logic lp);
    @(posedge aclk);
    low_power_mode <= lp;
    wdt_expiry <= 1'b1;
    @(posedge aclk);
    wdt_expiry <= 1'b0;
  endtask : wdt

  // ****
  // Sequence
  // ****
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      conclude();
    end
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {low_supply, low_power_mode, wdt_expiry, wdt_ctrl_illegal} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    reset_pin_n = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({wdt_expiry_flag, powerdown_flag}, 2'h0);
    rdc(`RSC_A_LEVEL, `RSC_LVL_POR);
    rdc(`RSC_A_PINSEL, `RSC_PIN_POR);
    rdc(`RSC_A_CAUSE, 32'h0);
    repeat (10) @(posedge aclk);
    for (int i = 0; i < 6; i++)
    begin
      wr(`RSC_A_LEVEL, codes[i]);
      rdc(`RSC_A_LEVEL, codes[i]);
      rd(`RSC_A_STATUS);
      chk(rdv[6:4], i);
      chk(brownout_enable, i < 5);
    end
    low_supply <= 1'b1;
    see(20, 2'h0);
    wr(`RSC_A_LEVEL, `RSC_LVL_1V7);
    low_power_mode <= 1'b1;
    low_supply <= 1'b1;
    see(20, 2'h0);
    chk(brownout_enable, 1'b0);
    low_power_mode <= 1'b0;
    wr(`RSC_A_LEVEL, `RSC_LVL_2V55);
    low_supply <= 1'b1;
    repeat (3) @(posedge aclk);
    low_supply <= 1'b0;
    see(12, 2'h0);
    low_supply <= 1'b1;
    see(16, 2'h3);
    rdc(`RSC_A_LEVEL, `RSC_LVL_2V55);
    rdc(`RSC_A_CAUSE, 32'h4);
    chk(irq, 1'b0);
    wr(`RSC_A_IRQ_EN, 32'h4);
    chk(irq, 1'b1);
    wr(`RSC_A_IRQ_CLR, 32'h4);
    chk(irq, 1'b0);
    rdc(`RSC_A_IRQ_EN, 32'h4);
    wr(`RSC_A_CAUSE, 32'hFF);
    rdc(`RSC_A_CAUSE, 32'h4);
    wr(`RSC_A_CAUSE, 32'h0);
    rdc(`RSC_A_CAUSE, 32'h0);
    wr(`RSC_A_LEVEL, 32'h12);
    see(10, 2'h3);
    rdc(`RSC_A_LEVEL, `RSC_LVL_POR);
    wr(`RSC_A_CAUSE, 32'hFF);
    rdc(`RSC_A_CAUSE, 32'h2);
    wr(`RSC_A_CAUSE, 32'h0);
    wr(`RSC_A_SELFPROG, 32'h54);
    see(4, 2'h0);
    wr(`RSC_A_SELFPROG, `RSC_SELFPROG_RST);
    see(4, 2'h3);
    rdc(`RSC_A_SELFPROG, 32'h0);
    wdt(1'b0);
    see(3, 2'h3);
    chk({wdt_expiry_flag, powerdown_flag}, 2'h2);
    wr(`RSC_A_LEVEL, `RSC_LVL_3V15);
    wdt(1'b1);
    see(3, 2'h1);
    chk({wdt_expiry_flag, powerdown_flag}, 2'h3);
    rdc(`RSC_A_LEVEL, `RSC_LVL_3V15);
    low_power_mode <= 1'b0;
    wr(`RSC_A_PINSEL, `RSC_PIN_RES);
    reset_pin_n <= 1'b0;
    see(10, 2'h3);
    chk({wdt_expiry_flag, powerdown_flag}, 2'h3);
    wr(`RSC_A_PINSEL, 32'h11);
    see(10, 2'h3);
    rdc(`RSC_A_CAUSE, 32'h8);
    // A watchdog control fault lands in the very cycle that software clears the causes.
    fork
      wr(`RSC_A_CAUSE, 32'h0);
      begin
        repeat (2) @(posedge aclk);
        wdt_ctrl_illegal <= 1'b1;
        @(posedge aclk);
        wdt_ctrl_illegal <= 1'b0;
      end
    join
    see(4, 2'h3);
    rdc(`RSC_A_CAUSE, 32'h1);
    rd(8'h20);
    chk(rsp, `RSC_RESP_SLVERR);
    chk(rdv, 32'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({wdt_expiry_flag, powerdown_flag}, 2'h0);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    conclude();
  end
endmodule : tb_top
